// File: inc/fmc_pkg.sv
// Functional notes
// - stage field 00 prologue, 01 main, 10 epilogue; 11 is not this group.
// - undefined when memory-ops feature absent or size field is not 00.
// - equal register numbers or any equal 31 give undefined or no-operation.
// - option bit 3 makes reads non-temporal, bit 2 makes writes non-temporal.
// - option bits 1/0 select unprivileged rule, else privileged above lowest level.
// - prologue saturates a count with bit 63 set to 0x7FFFFFFFFFFFFFFF.
// - algorithm A prologue clears flags, offsets addresses, negates count.
// - algorithm B prologue sets flags 0010 and counts bytes down.
// - algorithm A main/epilogue count is negative remaining, addresses offset by it.
// - main copies a chosen amount and writes count back in its algorithm's form.
// - epilogue finishes the copy and leaves the count at zero.
// - algorithm B writes back lowest addresses not yet read or written.
// - algorithm A loops while stage size nonzero, adding block to count.
// - algorithm B loops while stage size positive, advancing addresses by block.
// - main and epilogue validate incoming arguments before copying.
// - short block stops loop, records progress, raises abort tagged read or write.
//
// Purpose: constants and types for the forward memory copy executor
// Assumes: 32-bit AHB-Lite register access, 64-bit copy registers
// Notes: register offsets are byte addresses
package fmc_pkg;
  localparam logic [7:0] FMC_OFF_CTRL = 8'h00;
  localparam logic [7:0] FMC_OFF_INSTR = 8'h04;
  localparam logic [7:0] FMC_OFF_STATUS = 8'h08;
  localparam logic [7:0] FMC_OFF_SRC_LO = 8'h10;
  localparam logic [7:0] FMC_OFF_SRC_HI = 8'h14;
  localparam logic [7:0] FMC_OFF_DST_LO = 8'h18;
  localparam logic [7:0] FMC_OFF_DST_HI = 8'h1C;
  localparam logic [7:0] FMC_OFF_CNT_LO = 8'h20;
  localparam logic [7:0] FMC_OFF_CNT_HI = 8'h24;
  localparam int FMC_CTRL_FEAT = 0;
  localparam int FMC_CTRL_ALGB = 1;
  localparam int FMC_CTRL_ELNZ = 2;
  localparam int FMC_CTRL_UPRIV = 3;
  localparam int FMC_CTRL_NOP = 4;
  localparam logic [4:0] FMC_CTRL_RST = 5'h01;
  localparam int FMC_C_BIT = 1;
  localparam logic [1:0] FMC_STG_PRO = 2'h0;
  localparam logic [1:0] FMC_STG_MAIN = 2'h1;
  localparam logic [1:0] FMC_STG_EPI = 2'h2;
  localparam logic [1:0] FMC_SIZE_OK = 2'h0;
  localparam logic [4:0] FMC_REG_ZR = 5'h1F;
  localparam logic [5:0] FMC_FIX_HI = 6'h19;
  localparam logic [1:0] FMC_FIX_LO = 2'h1;
  localparam logic [3:0] FMC_OPT_FIXED = 4'h9;
  localparam logic [3:0] FMC_NZCV_A = 4'h0;
  localparam logic [3:0] FMC_NZCV_B = 4'h2;
  localparam logic [63:0] FMC_SAT = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [7:0] FMC_BLK = 8'h08;
  localparam logic [63:0] FMC_BLK_MASK = 64'hFFFF_FFFF_FFFF_FFF8;
  typedef enum logic [1:0] {
    FMC_IDLE = 2'b00,
    FMC_ISSUE = 2'b01,
    FMC_WAIT = 2'b10
  } fmc_state_t;
  typedef struct packed {
    logic [63:0] from_addr;
    logic [63:0] to_addr;
    logic [7:0] len;
    logic rd_nt;
    logic rd_priv;
    logic wr_nt;
    logic wr_priv;
  } fmc_mreq_t;
  typedef struct packed {
    logic busy;
    logic undef;
    logic nop;
    logic abort;
    logic abort_wr;
    logic [3:0] nzcv;
  } fmc_stat_t;
endpackage

// File: src/fmc_copy_exec.sv
// Purpose: executes the three-stage forward-only memory copy group
// Assumes: one 20 MHz clock, synchronous active-high reset, zero-wait AHB-Lite slave
// Notes: copy blocks go to the memory port, one outstanding request at a time
`timescale 1ns/100ps
module fmc_copy_exec
  import fmc_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic srst, // synchronous reset
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write access
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic mem_req_valid, // block request pending
  output fmc_mreq_t mem_req, // block request
  input wire logic mem_done, // block answered
  input wire logic [7:0] mem_copied, // bytes copied
  input wire logic mem_iswrite // short block failed on write
);
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hreadyout_reg;
  fmc_state_t state_reg, state_next;
  logic [4:0] ctrl_reg, ctrl_next;
  logic [63:0] src_reg, src_next, dst_reg, dst_next, cnt_reg, cnt_next;
  logic [63:0] stg_rem_reg, stg_rem_next;
  logic [3:0] opt_reg, opt_next;
  logic [1:0] stg_reg, stg_next;
  logic algb_reg, algb_next;
  fmc_stat_t stat_reg, stat_next;
  fmc_mreq_t mreq_reg, mreq_next;

  logic launch, d_form_ok, d_undef, d_clash, d_algb, d_bad_arg;
  logic [1:0] d_size, d_stg;
  logic [4:0] d_source_reg_field, d_count_reg_field, d_dest_reg_field;
  logic valid_reg, valid_next;
  logic [3:0] d_opt;
  logic [63:0] d_cnt, d_remain, cp64, blk64;
  logic [7:0] blk;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      FMC_OFF_CTRL: w = {27'h0, ctrl_reg};
      FMC_OFF_STATUS: w = {23'h0, stat_reg};
      FMC_OFF_SRC_LO: w = src_reg[31:0];
      FMC_OFF_SRC_HI: w = src_reg[63:32];
      FMC_OFF_DST_LO: w = dst_reg[31:0];
      FMC_OFF_DST_HI: w = dst_reg[63:32];
      FMC_OFF_CNT_LO: w = cnt_reg[31:0];
      FMC_OFF_CNT_HI: w = cnt_reg[63:32];
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // bus slave: address phase captured, read data registered for the data phase
  always_comb begin
    wr_pend_next = hsel && hready && htrans[1] && hwrite;
    waddr_next = haddr[7:0];
    hrdata_next = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata_next = rd_word(haddr[7:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      waddr_reg <= waddr_next;
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'b1;
    end
  end

  // instruction decode from the word written to the launch register
  assign launch = wr_pend_reg && (waddr_reg == FMC_OFF_INSTR) && (state_reg == FMC_IDLE);
  assign d_size = hwdata[31:30];
  assign d_stg = hwdata[23:22];
  assign d_source_reg_field = hwdata[20:16];
  assign d_opt = hwdata[15:12];
  assign d_count_reg_field = hwdata[9:5];
  assign d_dest_reg_field = hwdata[4:0];
  assign d_form_ok = (hwdata[29:24] == FMC_FIX_HI) && !hwdata[21]
    && (hwdata[11:10] == FMC_FIX_LO) && (d_opt == FMC_OPT_FIXED) && (d_stg != 2'h3);
  assign d_undef = !ctrl_reg[FMC_CTRL_FEAT] || (d_size != FMC_SIZE_OK) || !d_form_ok;
  assign d_clash = (d_source_reg_field == d_count_reg_field)
    || (d_source_reg_field == d_dest_reg_field)
    || (d_count_reg_field == d_dest_reg_field)
    || (d_source_reg_field == FMC_REG_ZR) || (d_count_reg_field == FMC_REG_ZR)
    || (d_dest_reg_field == FMC_REG_ZR);
  // algorithm from control at prologue, carried in the carry flag after
  assign d_algb = (d_stg == FMC_STG_PRO) ? ctrl_reg[FMC_CTRL_ALGB] : stat_reg.nzcv[FMC_C_BIT];
  assign d_cnt = ((d_stg == FMC_STG_PRO) && cnt_reg[63]) ? FMC_SAT : cnt_reg;
  assign d_bad_arg = (d_stg != FMC_STG_PRO)
    && (d_algb ? cnt_reg[63] : (!cnt_reg[63] && (cnt_reg != 64'h0)));
  assign d_remain = d_algb ? d_cnt : (64'h0 - d_cnt);
  assign blk = (stg_rem_reg < {56'h0, FMC_BLK}) ? stg_rem_reg[7:0] : FMC_BLK;
  assign blk64 = {56'h0, mreq_reg.len};
  assign cp64 = {56'h0, mem_copied};

  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    cnt_next = cnt_reg;
    stg_rem_next = stg_rem_reg;
    opt_next = opt_reg;
    stg_next = stg_reg;
    algb_next = algb_reg;
    stat_next = stat_reg;
    mreq_next = mreq_reg;
    if (wr_pend_reg && (state_reg == FMC_IDLE)) begin
      unique case (waddr_reg)
        FMC_OFF_CTRL: ctrl_next = hwdata[4:0];
        FMC_OFF_SRC_LO: src_next[31:0] = hwdata;
        FMC_OFF_SRC_HI: src_next[63:32] = hwdata;
        FMC_OFF_DST_LO: dst_next[31:0] = hwdata;
        FMC_OFF_DST_HI: dst_next[63:32] = hwdata;
        FMC_OFF_CNT_LO: cnt_next[31:0] = hwdata;
        FMC_OFF_CNT_HI: cnt_next[63:32] = hwdata;
        default: ;
      endcase
    end
    unique case (state_reg)
      FMC_IDLE: begin
        if (launch) begin
          stat_next.undef = 1'b0;
          stat_next.nop = 1'b0;
          stat_next.abort = 1'b0;
          stat_next.abort_wr = 1'b0;
          opt_next = d_opt;
          stg_next = d_stg;
          algb_next = d_algb;
          if (d_undef) begin
            stat_next.undef = 1'b1;
          end else if (d_clash) begin
            stat_next.nop = ctrl_reg[FMC_CTRL_NOP];
            stat_next.undef = !ctrl_reg[FMC_CTRL_NOP];
          end else if (d_bad_arg) begin
            stat_next.undef = 1'b1;
          end else begin
            if (d_stg == FMC_STG_PRO) begin
              cnt_next = d_cnt;
              if (!d_algb) begin
                stat_next.nzcv = FMC_NZCV_A;
                src_next = src_reg + d_cnt;
                dst_next = dst_reg + d_cnt;
                cnt_next = 64'h0 - d_cnt;
              end else begin
                stat_next.nzcv = FMC_NZCV_B;
              end
            end
            // main copies whole blocks, epilogue the rest
            unique case (d_stg)
              FMC_STG_MAIN: stg_rem_next = d_remain & FMC_BLK_MASK;
              FMC_STG_EPI: stg_rem_next = d_remain;
              default: stg_rem_next = 64'h0;
            endcase
            stat_next.busy = 1'b1;
            state_next = FMC_ISSUE;
          end
        end
      end
      FMC_ISSUE: begin
        if (stg_rem_reg == 64'h0) begin
          if (stg_reg == FMC_STG_EPI) begin
            cnt_next = 64'h0;
          end
          stat_next.busy = 1'b0;
          state_next = FMC_IDLE;
        end else begin
          mreq_next.len = blk;
          // algorithm A addresses at base plus negative count
          mreq_next.from_addr = algb_reg ? src_reg : (src_reg + cnt_reg);
          mreq_next.to_addr = algb_reg ? dst_reg : (dst_reg + cnt_reg);
          mreq_next.rd_nt = opt_reg[3];
          mreq_next.wr_nt = opt_reg[2];
          mreq_next.rd_priv = opt_reg[1] ? ctrl_reg[FMC_CTRL_UPRIV] : ctrl_reg[FMC_CTRL_ELNZ];
          mreq_next.wr_priv = opt_reg[0] ? ctrl_reg[FMC_CTRL_UPRIV] : ctrl_reg[FMC_CTRL_ELNZ];
          state_next = FMC_WAIT;
        end
      end
      FMC_WAIT: begin
        if (mem_done) begin
          if (mem_copied == mreq_reg.len) begin
            stg_rem_next = stg_rem_reg - blk64;
            state_next = FMC_ISSUE;
            if (algb_reg) begin
              src_next = src_reg + blk64;
              dst_next = dst_reg + blk64;
              cnt_next = cnt_reg - blk64;
            end else begin
              cnt_next = cnt_reg + blk64;
            end
          end else begin
            if (algb_reg) begin
              src_next = src_reg + cp64;
              dst_next = dst_reg + cp64;
              cnt_next = cnt_reg - cp64;
            end else begin
              cnt_next = cnt_reg + cp64;
            end
            stat_next.abort = 1'b1;
            stat_next.abort_wr = mem_iswrite;
            stat_next.busy = 1'b0;
            state_next = FMC_IDLE;
          end
        end
      end
      default: state_next = FMC_IDLE;
    endcase
    // request valid registered so the pin comes straight from a flop
    valid_next = (state_next == FMC_WAIT);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= FMC_IDLE;
      ctrl_reg <= FMC_CTRL_RST;
      src_reg <= 64'h0;
      dst_reg <= 64'h0;
      cnt_reg <= 64'h0;
      stg_rem_reg <= 64'h0;
      opt_reg <= 4'h0;
      stg_reg <= FMC_STG_PRO;
      algb_reg <= 1'b0;
      stat_reg <= '0;
      mreq_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      cnt_reg <= cnt_next;
      stg_rem_reg <= stg_rem_next;
      opt_reg <= opt_next;
      stg_reg <= stg_next;
      algb_reg <= algb_next;
      stat_reg <= stat_next;
      mreq_reg <= mreq_next;
      valid_reg <= valid_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign mem_req_valid = valid_reg;
  assign mem_req = mreq_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_stage_reserved: assert property (launch && d_stg == 2'h3 |=> stat_reg.undef)
    else $error("reserved stage not undefined");
  a_size_undef: assert property (launch && d_size != FMC_SIZE_OK
    |=> stat_reg.undef && !stat_reg.busy)
    else $error("bad size not undefined");
  a_reg_clash: assert property (launch && !d_undef && d_clash
    |=> (stat_reg.undef ^ stat_reg.nop) && state_reg == FMC_IDLE)
    else $error("register clash executed");
  a_nt_hints: assert property (mem_req_valid |-> mem_req.rd_nt && !mem_req.wr_nt)
    else $error("temporal hints wrong");
  a_priv_sel: assert property (mem_req_valid |-> mem_req.rd_priv == ctrl_reg[FMC_CTRL_ELNZ]
    && mem_req.wr_priv == ctrl_reg[FMC_CTRL_UPRIV])
    else $error("privilege wrong");
  a_sat_neg: assert property (launch && !d_undef && !d_clash && d_stg == FMC_STG_PRO
    && !d_algb && cnt_reg[63] |=> cnt_reg == 64'h0 - FMC_SAT)
    else $error("count not saturated");
  a_pro_flags: assert property (launch && !d_undef && !d_clash && d_stg == FMC_STG_PRO
    |=> stat_reg.nzcv == ($past(d_algb) ? FMC_NZCV_B : FMC_NZCV_A))
    else $error("prologue flags wrong");
  a_blk_len: assert property (mem_req_valid |-> mem_req.len != 8'h0 && mem_req.len <= FMC_BLK)
    else $error("block length out of range");
  a_epi_zero: assert property ($fell(stat_reg.busy) && stg_reg == FMC_STG_EPI && !stat_reg.abort
    |-> cnt_reg == 64'h0)
    else $error("epilogue left count");
  a_short_abort: assert property (mem_req_valid && mem_done && mem_copied != mem_req.len
    |=> state_reg == FMC_IDLE && stat_reg.abort && stat_reg.abort_wr == $past(mem_iswrite))
    else $error("short block not aborted");
  a_step_b: assert property (mem_req_valid && mem_done && mem_copied == mem_req.len && algb_reg
    |=> src_reg == $past(src_reg) + $past(blk64) && state_reg == FMC_ISSUE)
    else $error("source not advanced");

  c_main_done: cover property ($fell(stat_reg.busy) && stg_reg == FMC_STG_MAIN && !stat_reg.abort);
  c_epi_b: cover property ($fell(stat_reg.busy) && stg_reg == FMC_STG_EPI && algb_reg);
  c_abort: cover property ($rose(stat_reg.abort));
endmodule

// File: sim/fmc_mem_model.sv
// Purpose: memory side partner that answers copy block requests
// Assumes: one request outstanding, answer after dly idle cycles
// Notes: request number fail_at comes back three bytes short
`timescale 1ns/100ps
module fmc_mem_model
  import fmc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic mem_req_valid, // request pending
  input wire fmc_mreq_t mem_req, // request
  output logic mem_done, // answer pulse
  output logic [7:0] mem_copied, // bytes copied
  output logic mem_iswrite, // failed side
  input wire logic [3:0] dly, // answer delay
  input wire logic [7:0] fail_at, // failing request number
  input wire logic fail_wr // failing side
);
  logic [3:0] wait_reg;
  logic [7:0] num_reg;
  always_ff @(posedge clk) begin
    mem_done <= 1'b0;
    // outside an answer the lines carry changing garbage
    mem_copied <= mem_copied + 8'h35;
    mem_iswrite <= ~mem_iswrite;
    if (srst) begin
      wait_reg <= 4'h0;
      num_reg <= 8'h00;
      mem_copied <= 8'h00;
      mem_iswrite <= 1'b0;
    end else if (mem_req_valid && !mem_done) begin
      if (wait_reg == dly) begin
        wait_reg <= 4'h0;
        num_reg <= num_reg + 8'h01;
        mem_done <= 1'b1;
        mem_copied <= mem_req.len;
        mem_iswrite <= 1'b0;
        if (num_reg + 8'h01 == fail_at) begin
          mem_copied <= mem_req.len - 8'h03;
          mem_iswrite <= fail_wr;
        end
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for the forward memory copy executor
// Assumes: zero-wait bus slave, partner model on the memory port
// Notes: expected block requests queue up and are checked as answered
`timescale 1ns/100ps
module testbench
  import fmc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, mem_req_valid, mem_done, mem_iswrite;
  logic fail_wr = 1'b0;
  logic [7:0] mem_copied;
  logic [7:0] fail_at = 8'h00;
  logic [7:0] n_req = 8'h00;
  logic [3:0] dly = 4'h0;
  logic [4:0] ctrl_reg = 5'h01;
  fmc_mreq_t mem_req;
  fmc_mreq_t exp_q[$];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  fmc_copy_exec i_dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_done(mem_done), .mem_copied(mem_copied),
    .mem_iswrite(mem_iswrite));
  fmc_mem_model i_mem (.clk(clk), .srst(srst), .mem_req_valid(mem_req_valid),
    .mem_req(mem_req), .mem_done(mem_done), .mem_copied(mem_copied),
    .mem_iswrite(mem_iswrite), .dly(dly), .fail_at(fail_at), .fail_wr(fail_wr));
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    if (!srst && mem_req_valid === 1'b1 && mem_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(1, 0);
      end else begin
        chk(mem_req, exp_q.pop_front());
      end
    end
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk(hresp, 0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic w64(input logic [7:0] a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
  endtask
  task automatic r64(input logic [7:0] a, input logic [63:0] e);
    rdc(a, '1, e[31:0]);
    rdc(a + 8'h04, '1, e[63:32]);
  endtask
  // privilege selects are random on every control write
  task automatic setc(input logic [4:0] c);
    ctrl_reg = {c[4], 2'($urandom), c[1:0]};
    wr(FMC_OFF_CTRL, {27'h0, ctrl_reg});
  endtask
  function automatic logic [31:0] mk(input logic [1:0] fsize, input logic [1:0] st,
      input logic [4:0] src_f, input logic [4:0] cnt_f, input logic [4:0] dst_f);
    return {fsize, FMC_FIX_HI, st, 1'b0, src_f, FMC_OPT_FIXED, FMC_FIX_LO, cnt_f, dst_f};
  endfunction
  task automatic run(input logic [31:0] ins, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    int k;
    wr(FMC_OFF_INSTR, ins);
    k = 0;
    do begin
      xfer(1'b0, FMC_OFF_STATUS, 32'h0, q);
      k++;
    end while (q[8] !== 1'b0 && k < 300);
    chk(q & m, e);
    chk(exp_q.size(), 0);
  endtask
  task automatic blk(input logic [63:0] f, input logic [63:0] t, input logic [7:0] n);
    exp_q.push_back({f, t, n, 1'b1, ctrl_reg[2], 1'b0, ctrl_reg[3]});
    n_req = n_req + 8'h01;
  endtask
  // prologue, main and epilogue in order, no overlap
  task automatic copy3(input logic b, input logic [63:0] n);
    logic [63:0] s, d, m;
    logic [31:0] z;
    setc({3'h0, b, 1'b1});
    s = {32'h0000_0001, 32'($urandom)};
    d = s + 64'h1000;
    m = n & FMC_BLK_MASK;
    z = {28'h0, b ? FMC_NZCV_B : FMC_NZCV_A};
    w64(FMC_OFF_SRC_LO, s);
    w64(FMC_OFF_DST_LO, d);
    w64(FMC_OFF_CNT_LO, n);
    run(mk(2'h0, FMC_STG_PRO, 5'h01, 5'h02, 5'h03), 32'h1FF, z);
    r64(FMC_OFF_CNT_LO, b ? n : -n);
    r64(FMC_OFF_SRC_LO, b ? s : s + n);
    for (int i = 0; i < m; i += 8) blk(s + i, d + i, 8'h08);
    run(mk(2'h0, FMC_STG_MAIN, 5'h01, 5'h02, 5'h03), 32'h1FF, z);
    r64(FMC_OFF_CNT_LO, b ? n - m : m - n);
    r64(FMC_OFF_DST_LO, b ? d + m : d + n);
    if (n != m) blk(s + m, d + m, 8'(n - m));
    run(mk(2'h0, FMC_STG_EPI, 5'h01, 5'h02, 5'h03), 32'h1FF, z);
    r64(FMC_OFF_CNT_LO, 64'h0);
    r64(FMC_OFF_SRC_LO, s + n);
    $display("test copy alg=%0d n=%0d done", b, n);
  endtask
  task automatic fault(input logic b, input logic w);
    setc({3'h0, b, 1'b1});
    w64(FMC_OFF_SRC_LO, 64'h2000);
    w64(FMC_OFF_DST_LO, 64'h8000);
    w64(FMC_OFF_CNT_LO, 64'h18);
    run(mk(2'h0, FMC_STG_PRO, 5'h04, 5'h05, 5'h06), 32'h1F0, 32'h0);
    blk(64'h2000, 64'h8000, 8'h08);
    blk(64'h2008, 64'h8008, 8'h08);
    fail_at <= n_req;
    fail_wr <= w;
    run(mk(2'h0, FMC_STG_MAIN, 5'h04, 5'h05, 5'h06), 32'h1F0, {26'h1, w, 4'h0});
    r64(FMC_OFF_CNT_LO, b ? 64'hB : -64'hB);
    r64(FMC_OFF_DST_LO, b ? 64'h800D : 64'h8018);
    fail_at <= 8'h00;
    $display("test fault alg=%0d wr=%0d done", b, w);
  endtask
  initial begin
    logic [31:0] ti[7];
    logic [4:0] tc[7];
    logic [31:0] te[7];
    void'($urandom(32'h06F8));
    ti = '{mk(2'h1, 2'h0, 1, 2, 3), mk(2'h0, 2'h3, 1, 2, 3), mk(2'h0, 2'h0, 1, 2, 3),
      mk(2'h0, 2'h0, 1, 1, 3), mk(2'h0, 2'h1, 1, 2, 2), mk(2'h0, 2'h2, 1, 2, 31),
      mk(2'h0, 2'h0, 1, 2, 3) ^ 32'h1000};
    tc = '{5'h01, 5'h01, 5'h00, 5'h01, 5'h11, 5'h11, 5'h01};
    te = '{32'h80, 32'h80, 32'h80, 32'h80, 32'h40, 32'h40, 32'h80};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdc(FMC_OFF_CTRL, 32'h1F, {27'h0, FMC_CTRL_RST});
    rdc(FMC_OFF_STATUS, '1, 32'h0);
    wr(8'h44, 32'hFFFF_FFFF);
    rdc(8'h44, '1, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 7; k++) begin
      setc(tc[k]);
      run(ti[k], 32'h1C0, te[k]);
    end
    $display("test decode done");
    for (int b = 0; b < 2; b++) begin
      setc({3'h0, 1'(b), 1'b1});
      w64(FMC_OFF_SRC_LO, 64'h100);
      w64(FMC_OFF_CNT_LO, 64'h8000_0000_0000_0005);
      run(mk(2'h0, FMC_STG_PRO, 1, 2, 3), 32'h1C0, 32'h0);
      r64(FMC_OFF_CNT_LO, b ? FMC_SAT : -FMC_SAT);
      r64(FMC_OFF_SRC_LO, b ? 64'h100 : 64'h100 + FMC_SAT);
      w64(FMC_OFF_CNT_LO, b ? 64'h8000_0000_0000_0000 : 64'h10);
      run(mk(2'h0, FMC_STG_MAIN, 1, 2, 3), 32'h1C0, 32'h80);
    end
    $display("test saturate and check done");
    copy3(1'b1, 64'h15);
    dly <= 4'h3;
    copy3(1'b0, 64'h14);
    dly <= 4'h0;
    // algorithm choice left random
    copy3(1'($urandom), 64'($urandom_range(40, 1)));
    fault(1'b1, 1'b1);
    fault(1'b0, 1'b0);
    print_verdict();
  end
endmodule
